// file: rtl/haptic_level_pkg.sv
// Package with the offsets, reset values and scale constants of the audio level configuration block
// Function
// - Audio levels below the programmed input floor are ignored; floor volts = code*1.8/255.
// - The input full-scale code sets full-scale audio level; volts = code*1.8/255.
// - Audio output passed to the drive engine never exceeds the drive ceiling code.
// - Closed loop uses the rated level code as the full-scale reference.
// - Open loop ignores the rated level code; the overdrive setting is the reference.
// - Closed-loop overdrive and braking excursions are bounded by the overdrive limit code.
// - Open loop uses the overdrive limit code as the full-scale output reference.
package haptic_level_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int NUM_W = 16;

  localparam logic [ADDR_W-1:0] AUDIO_INPUT_FLOOR_OFS = 8'h12;
  localparam logic [ADDR_W-1:0] AUDIO_INPUT_FULL_SCALE_OFS = 8'h13;
  localparam logic [ADDR_W-1:0] AUDIO_DRIVE_FLOOR_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] AUDIO_DRIVE_CEILING_OFS = 8'h15;
  localparam logic [ADDR_W-1:0] ACTUATOR_RATED_LEVEL_OFS = 8'h16;
  localparam logic [ADDR_W-1:0] OVERDRIVE_LIMIT_OFS = 8'h17;
  localparam logic [ADDR_W-1:0] AUDIO_DRIVE_RESULT_OFS = 8'h30;

  localparam logic [DATA_W-1:0] AUDIO_INPUT_FLOOR_RST = 8'h19;
  localparam logic [DATA_W-1:0] AUDIO_INPUT_FULL_SCALE_RST = 8'hff;
  localparam logic [DATA_W-1:0] AUDIO_DRIVE_FLOOR_RST = 8'h19;
  localparam logic [DATA_W-1:0] AUDIO_DRIVE_CEILING_RST = 8'hff;
  localparam logic [DATA_W-1:0] ACTUATOR_RATED_LEVEL_RST = 8'h3f;
  localparam logic [DATA_W-1:0] OVERDRIVE_LIMIT_RST = 8'h89;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

  // Code 255 stands for 1.8 V peak-to-peak input, or 100 % drive
  localparam int CODE_FULL = 255;
  localparam int INPUT_FULL_MV = 1800;
  localparam int DRIVE_FULL_PCT = 100;

  localparam logic [4:0] DIV_STEPS = 5'h10;
endpackage

// file: rtl/level_divider.sv
// Serial restoring divider, 16-bit dividend by 8-bit divisor
`timescale 1ns/10ps
module level_divider
  import haptic_level_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic start,
  input wire logic [NUM_W-1:0] num,
  input wire logic [DATA_W-1:0] den,
  output logic busy,
  output logic done,
  output logic [NUM_W-1:0] quot
);
  logic [DATA_W-1:0] rem;
  logic [NUM_W-1:0] dvd;
  logic [4:0] cnt;
  wire [DATA_W:0] trial = {rem, dvd[NUM_W-1]};
  wire fits = trial >= {1'b0, den};
  wire [DATA_W:0] diff = trial - {1'b0, den};
  // A zero divisor always fits, so the quotient saturates to all ones
  assign quot = dvd;

  always_ff @(posedge CLK) begin
    if (RST) begin
      rem <= '0;
      dvd <= '0;
      cnt <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        rem <= '0;
        dvd <= num;
        cnt <= DIV_STEPS;
        busy <= 1'b1;
      end else if (busy) begin
        rem <= fits ? diff[DATA_W-1:0] : trial[DATA_W-1:0];
        dvd <= {dvd[NUM_W-2:0], fits};
        cnt <= cnt - 5'h01;
        if (cnt == 5'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

  busy_len_a: assert property (@(posedge CLK) disable iff (RST)
    start && !busy |=> busy [*8])
    else $error("divider busy ended early");
endmodule

// file: rtl/haptic_level_config.sv
// Audio-to-vibe level window, drive window and full-scale reference registers
`timescale 1ns/10ps
module haptic_level_config
  import haptic_level_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic REG_WE,
  input wire logic REG_RE,
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic [DATA_W-1:0] REG_WDATA,
  output logic [DATA_W-1:0] REG_RDATA,
  input wire logic AUDIO_VALID,
  input wire logic [DATA_W-1:0] AUDIO_LEVEL,
  output logic AUDIO_BUSY,
  output logic AUDIO_DRIVE_VALID,
  output logic [DATA_W-1:0] AUDIO_DRIVE,
  input wire logic CLOSED_LOOP,
  input wire logic [DATA_W-1:0] DRIVE_DEMAND,
  output logic [DATA_W-1:0] DRIVE_VOLTAGE,
  output logic [DATA_W-1:0] FULL_SCALE_REF
);
  logic [DATA_W-1:0] audio_input_floor;
  logic [DATA_W-1:0] audio_input_full_scale;
  logic [DATA_W-1:0] audio_drive_floor;
  logic [DATA_W-1:0] audio_drive_ceiling;
  logic [DATA_W-1:0] actuator_rated_level;
  logic [DATA_W-1:0] overdrive_limit;
  logic [DATA_W-1:0] floor_s;
  logic [DATA_W-1:0] ceil_s;
  logic sat_s;
  logic pending;
  logic div_busy;
  logic div_done;
  logic [NUM_W-1:0] div_quot;

  // Register decode
  wire hit_in_floor = REG_ADDR == AUDIO_INPUT_FLOOR_OFS;
  wire hit_in_full = REG_ADDR == AUDIO_INPUT_FULL_SCALE_OFS;
  wire hit_dr_floor = REG_ADDR == AUDIO_DRIVE_FLOOR_OFS;
  wire hit_dr_ceil = REG_ADDR == AUDIO_DRIVE_CEILING_OFS;
  wire hit_rated = REG_ADDR == ACTUATOR_RATED_LEVEL_OFS;
  wire hit_od = REG_ADDR == OVERDRIVE_LIMIT_OFS;
  wire hit_result = REG_ADDR == AUDIO_DRIVE_RESULT_OFS;
  wire [DATA_W-1:0] next_rdata =
    hit_in_floor ? audio_input_floor :
    hit_in_full ? audio_input_full_scale :
    hit_dr_floor ? audio_drive_floor :
    hit_dr_ceil ? audio_drive_ceiling :
    hit_rated ? actuator_rated_level :
    hit_od ? overdrive_limit :
    hit_result ? AUDIO_DRIVE : UNMAPPED_READ;

  // Level mapping: input window [floor, full] onto drive window [drive floor, ceiling]
  wire accept = AUDIO_VALID && !pending;
  wire below_floor = AUDIO_LEVEL < audio_input_floor;
  wire at_full = AUDIO_LEVEL >= audio_input_full_scale;
  wire [DATA_W-1:0] level_clip = at_full ? audio_input_full_scale : AUDIO_LEVEL;
  wire [DATA_W-1:0] in_span = (audio_input_full_scale > audio_input_floor) ?
    audio_input_full_scale - audio_input_floor : '0;
  wire [DATA_W-1:0] in_offset = (level_clip > audio_input_floor) ? level_clip - audio_input_floor : '0;
  wire [DATA_W-1:0] out_span = (audio_drive_ceiling > audio_drive_floor) ?
    audio_drive_ceiling - audio_drive_floor : '0;
  wire [NUM_W-1:0] div_num = in_offset * out_span;
  wire [NUM_W:0] drive_sum = {1'b0, div_quot} + {{(NUM_W-DATA_W+1){1'b0}}, floor_s};
  // An empty input window divides by zero and saturates, so any level at or above the floor gives full drive
  wire over_ceil = drive_sum > {{(NUM_W-DATA_W+1){1'b0}}, ceil_s};
  wire [DATA_W-1:0] next_drive = over_ceil ? ceil_s : drive_sum[DATA_W-1:0];

  // Full-scale reference and overdrive bound
  wire [DATA_W-1:0] next_ref = CLOSED_LOOP ? actuator_rated_level : overdrive_limit;
  wire [DATA_W-1:0] next_voltage = (DRIVE_DEMAND > overdrive_limit) ? overdrive_limit : DRIVE_DEMAND;

  assign AUDIO_BUSY = pending;

  level_divider u_div (
    .CLK(CLK),
    .RST(RST),
    .start(accept && !below_floor),
    .num(div_num),
    .den(in_span),
    .busy(div_busy),
    .done(div_done),
    .quot(div_quot)
  );

  always_ff @(posedge CLK) begin
    if (RST) begin
      audio_input_floor <= AUDIO_INPUT_FLOOR_RST;
      audio_input_full_scale <= AUDIO_INPUT_FULL_SCALE_RST;
      audio_drive_floor <= AUDIO_DRIVE_FLOOR_RST;
      audio_drive_ceiling <= AUDIO_DRIVE_CEILING_RST;
      actuator_rated_level <= ACTUATOR_RATED_LEVEL_RST;
      overdrive_limit <= OVERDRIVE_LIMIT_RST;
    end else if (REG_WE) begin
      if (hit_in_floor) audio_input_floor <= REG_WDATA;
      if (hit_in_full) audio_input_full_scale <= REG_WDATA;
      if (hit_dr_floor) audio_drive_floor <= REG_WDATA;
      if (hit_dr_ceil) audio_drive_ceiling <= REG_WDATA;
      if (hit_rated) actuator_rated_level <= REG_WDATA;
      if (hit_od) overdrive_limit <= REG_WDATA;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      REG_RDATA <= '0;
    end else if (REG_RE) begin
      REG_RDATA <= next_rdata;
    end
  end

  // Drive window is snapshotted per sample so a drive floor or ceiling write mid-division cannot tear the result
  always_ff @(posedge CLK) begin
    if (RST) begin
      pending <= 1'b0;
      floor_s <= '0;
      ceil_s <= '0;
      sat_s <= 1'b0;
      AUDIO_DRIVE_VALID <= 1'b0;
      AUDIO_DRIVE <= '0;
    end else begin
      AUDIO_DRIVE_VALID <= 1'b0;
      if (accept && below_floor) begin
        AUDIO_DRIVE <= '0;
        AUDIO_DRIVE_VALID <= 1'b1;
        sat_s <= 1'b0;
        ceil_s <= audio_drive_ceiling;
        floor_s <= audio_drive_floor;
      end else if (accept) begin
        pending <= 1'b1;
        sat_s <= at_full;
        ceil_s <= audio_drive_ceiling;
        floor_s <= audio_drive_floor;
      end else if (div_done) begin
        pending <= 1'b0;
        AUDIO_DRIVE <= next_drive;
        AUDIO_DRIVE_VALID <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      FULL_SCALE_REF <= ACTUATOR_RATED_LEVEL_RST;
      DRIVE_VOLTAGE <= '0;
    end else begin
      FULL_SCALE_REF <= next_ref;
      DRIVE_VOLTAGE <= next_voltage;
    end
  end

  below_floor_a: assert property (@(posedge CLK) disable iff (RST)
    accept && below_floor |=> AUDIO_DRIVE_VALID && AUDIO_DRIVE == 8'h00)
    else $error("level below floor was not ignored");
  full_scale_a: assert property (@(posedge CLK) disable iff (RST)
    AUDIO_DRIVE_VALID && sat_s |-> AUDIO_DRIVE == ceil_s)
    else $error("full-scale input did not give full drive");
  drive_ceiling_a: assert property (@(posedge CLK) disable iff (RST)
    AUDIO_DRIVE_VALID |-> AUDIO_DRIVE <= ceil_s)
    else $error("audio drive above ceiling");
  drive_floor_a: assert property (@(posedge CLK) disable iff (RST)
    AUDIO_DRIVE_VALID && AUDIO_DRIVE != 8'h00 |-> AUDIO_DRIVE >= floor_s || AUDIO_DRIVE == ceil_s)
    else $error("detected audio below drive floor");
  drive_latency_a: assert property (@(posedge CLK) disable iff (RST)
    accept && !below_floor |-> ##[17:18] AUDIO_DRIVE_VALID)
    else $error("audio drive result late");
  rated_ref_a: assert property (@(posedge CLK) disable iff (RST)
    CLOSED_LOOP |=> FULL_SCALE_REF == $past(actuator_rated_level))
    else $error("closed loop reference is not the rated level");
  open_ref_a: assert property (@(posedge CLK) disable iff (RST)
    !CLOSED_LOOP |=> FULL_SCALE_REF == $past(overdrive_limit))
    else $error("open loop reference is not the overdrive limit");
  limit_clamp_a: assert property (@(posedge CLK) disable iff (RST)
    1'b1 |=> DRIVE_VOLTAGE <= $past(overdrive_limit) &&
      (DRIVE_VOLTAGE == $past(DRIVE_DEMAND) || DRIVE_VOLTAGE == $past(overdrive_limit)))
    else $error("drive voltage not bounded by overdrive limit");

  // Register writes land at the strobe edge and are visible one edge later
  floor_write_a: assert property (@(posedge CLK) disable iff (RST)
    REG_WE && hit_in_floor |=> audio_input_floor == $past(REG_WDATA))
    else $error("input floor write lost");
  full_write_a: assert property (@(posedge CLK) disable iff (RST)
    REG_WE && hit_in_full |=> audio_input_full_scale == $past(REG_WDATA))
    else $error("input full-scale write lost");
  ceil_write_a: assert property (@(posedge CLK) disable iff (RST)
    REG_WE && hit_dr_ceil |=> audio_drive_ceiling == $past(REG_WDATA))
    else $error("drive ceiling write lost");
  drive_floor_write_a: assert property (@(posedge CLK) disable iff (RST)
    REG_WE && hit_dr_floor |=> audio_drive_floor == $past(REG_WDATA))
    else $error("drive floor write lost");
  rated_write_a: assert property (@(posedge CLK) disable iff (RST)
    REG_WE && hit_rated |=> actuator_rated_level == $past(REG_WDATA))
    else $error("rated level write lost");
  limit_write_a: assert property (@(posedge CLK) disable iff (RST)
    REG_WE && hit_od |=> overdrive_limit == $past(REG_WDATA))
    else $error("overdrive limit write lost");
  result_read_a: assert property (@(posedge CLK) disable iff (RST)
    REG_RE && hit_result |=> REG_RDATA == $past(AUDIO_DRIVE))
    else $error("result register does not mirror the drive level");

  // Busy must cover the whole division, or a second sample could restart the divider mid-result
  drive_busy_a: assert property (@(posedge CLK) disable iff (RST)
    accept && !below_floor |=> AUDIO_BUSY)
    else $error("mapped sample did not raise busy");
  ignored_idle_a: assert property (@(posedge CLK) disable iff (RST)
    accept && below_floor |=> !AUDIO_BUSY)
    else $error("ignored sample raised busy");
  div_guard_a: assert property (@(posedge CLK) disable iff (RST)
    div_busy |-> AUDIO_BUSY)
    else $error("divider running while audio path idle");
  refused_quiet_a: assert property (@(posedge CLK) disable iff (RST)
    AUDIO_BUSY && !div_done |=> !AUDIO_DRIVE_VALID)
    else $error("result strobe while a division is pending");

  cov_ignored_c: cover property (@(posedge CLK) disable iff (RST) accept && below_floor);
  cov_mapped_c: cover property (@(posedge CLK) disable iff (RST)
    div_done ##1 AUDIO_DRIVE_VALID && AUDIO_DRIVE > ceil_s - 8'h01 == 1'b0);
  cov_saturate_c: cover property (@(posedge CLK) disable iff (RST) AUDIO_DRIVE_VALID && sat_s);
  cov_mode_swap_c: cover property (@(posedge CLK) disable iff (RST) CLOSED_LOOP ##1 !CLOSED_LOOP);
  cov_refused_c: cover property (@(posedge CLK) disable iff (RST) AUDIO_BUSY && AUDIO_VALID);
endmodule

// file: sim/haptic_level_config_tb_top.sv
// Self-checking bench for the audio level window and full-scale reference registers
`timescale 1ns/10ps
module haptic_level_config_tb_top
  import haptic_level_pkg::*;
;
  logic CLK = 1'b0, RST = 1'b1, REG_WE = 1'b0, REG_RE = 1'b0, AUDIO_VALID = 1'b0, CLOSED_LOOP = 1'b0;
  logic [ADDR_W-1:0] REG_ADDR = 8'h00;
  logic [DATA_W-1:0] REG_WDATA = 8'h00, AUDIO_LEVEL = 8'h00, DRIVE_DEMAND = 8'h00;
  logic [DATA_W-1:0] REG_RDATA, AUDIO_DRIVE, DRIVE_VOLTAGE, FULL_SCALE_REF;
  logic AUDIO_BUSY, AUDIO_DRIVE_VALID;
  int failures = 0, checks_done = 0;
  always #25 CLK = ~CLK;
  haptic_level_config uut (.CLK(CLK), .RST(RST), .REG_WE(REG_WE), .REG_RE(REG_RE), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .AUDIO_VALID(AUDIO_VALID), .AUDIO_LEVEL(AUDIO_LEVEL),
    .AUDIO_BUSY(AUDIO_BUSY), .AUDIO_DRIVE_VALID(AUDIO_DRIVE_VALID), .AUDIO_DRIVE(AUDIO_DRIVE),
    .CLOSED_LOOP(CLOSED_LOOP), .DRIVE_DEMAND(DRIVE_DEMAND), .DRIVE_VOLTAGE(DRIVE_VOLTAGE),
    .FULL_SCALE_REF(FULL_SCALE_REF));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK) #2;
    REG_WE = 1'b1; REG_ADDR = a; REG_WDATA = d;
    @(posedge CLK) #2;
    REG_WE = 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLK) #2;
    REG_RE = 1'b1; REG_ADDR = a;
    @(posedge CLK) #2;
    REG_RE = 1'b0; d = REG_RDATA;
  endtask
  // Bounded wait for the drive result pulse; n counts edges after the accept edge
  task automatic wait_drive(output int n);
    for (n = 0; n < 40 && AUDIO_DRIVE_VALID !== 1'b1; n++) @(posedge CLK) #2;
    if (n == 40) begin
      failures++;
      give_verdict();
    end
  endtask
  // Offers one sample, checks result latency and that the result strobe is one cycle wide
  task automatic audio(input logic [7:0] lvl, input logic exp_busy, output logic [7:0] d);
    int n;
    @(posedge CLK) #2;
    AUDIO_VALID = 1'b1; AUDIO_LEVEL = lvl;
    @(posedge CLK) #2;
    AUDIO_VALID = 1'b0;
    check({7'h00, AUDIO_BUSY}, {7'h00, exp_busy});
    wait_drive(n);
    check(8'(n), exp_busy ? 8'h11 : 8'h00);
    check({7'h00, AUDIO_BUSY}, 8'h00);
    d = AUDIO_DRIVE;
    @(posedge CLK) #2;
    check({7'h00, AUDIO_DRIVE_VALID}, 8'h00);
  endtask
  // A sample offered while busy is dropped and leaves the first result intact
  task automatic test_refuse();
    int n;
    @(posedge CLK) #2;
    AUDIO_VALID = 1'b1; AUDIO_LEVEL = 8'h60;
    @(posedge CLK) #2;
    AUDIO_LEVEL = 8'h00;
    @(posedge CLK) #2;
    AUDIO_VALID = 1'b0;
    check({7'h00, AUDIO_DRIVE_VALID}, 8'h00);
    wait_drive(n);
    check(AUDIO_DRIVE, exp_drive(8'h60, 8'h20, 8'h80, 8'h30, 8'h50));
    $display("test_refuse done");
  endtask
  // Independent model of the window mapping, kept apart from the design's arithmetic
  function automatic logic [7:0] exp_drive(int lvl, int fl, int fs, int df, int ce);
    int lc, q;
    if (lvl < fl) return 8'h00;
    lc = (lvl < fs) ? lvl : fs;
    q = (fs > fl) ? ((lc - fl) * ((ce > df) ? ce - df : 0)) / (fs - fl) : 65535;
    return ((df + q) < ce) ? 8'(df + q) : 8'(ce);
  endfunction
  task automatic test_reset();
    logic [7:0] d;
    check(FULL_SCALE_REF, 8'h3f);
    check(DRIVE_VOLTAGE, 8'h00);
    check(AUDIO_DRIVE, 8'h00);
    reg_rd(AUDIO_INPUT_FLOOR_OFS, d); check(d, 8'h19);
    reg_rd(AUDIO_INPUT_FULL_SCALE_OFS, d); check(d, 8'hff);
    reg_rd(AUDIO_DRIVE_FLOOR_OFS, d); check(d, AUDIO_DRIVE_FLOOR_RST);
    reg_rd(AUDIO_DRIVE_CEILING_OFS, d); check(d, 8'hff);
    reg_rd(ACTUATOR_RATED_LEVEL_OFS, d); check(d, 8'h3f);
    reg_rd(OVERDRIVE_LIMIT_OFS, d); check(d, 8'h89);
    reg_rd(8'h05, d); check(d, UNMAPPED_READ);
    $display("test_reset done");
  endtask
  task automatic test_regs();
    logic [7:0] d;
    for (int i = 0; i < 6; i++) reg_wr(8'(8'h12 + i), 8'(8'ha5 ^ i));
    for (int i = 0; i < 6; i++) begin
      reg_rd(8'(8'h12 + i), d);
      check(d, 8'(8'ha5 ^ i));
    end
    reg_wr(8'h1f, 8'h5a);
    reg_rd(8'h1f, d); check(d, UNMAPPED_READ);
    $display("test_regs done");
  endtask
  task automatic test_ref(input logic cl, input logic [7:0] dem, input logic [7:0] ref_e, input logic [7:0] v_e);
    @(posedge CLK) #2;
    CLOSED_LOOP = cl; DRIVE_DEMAND = dem;
    @(posedge CLK) #2;
    check(FULL_SCALE_REF, ref_e);
    check(DRIVE_VOLTAGE, v_e);
  endtask
  task automatic test_audio(input logic [7:0] fl, input logic [7:0] fs, input logic [7:0] df, input logic [7:0] ce);
    logic [7:0] d;
    logic [7:0] lv[5];
    lv = '{8'h00, 8'(fl - 1), fl, 8'h60, 8'hff};
    reg_wr(AUDIO_INPUT_FLOOR_OFS, fl); reg_wr(AUDIO_INPUT_FULL_SCALE_OFS, fs);
    reg_wr(AUDIO_DRIVE_FLOOR_OFS, df); reg_wr(AUDIO_DRIVE_CEILING_OFS, ce);
    foreach (lv[i]) begin
      audio(lv[i], lv[i] >= fl, d);
      check(d, exp_drive(lv[i], fl, fs, df, ce));
    end
    reg_rd(AUDIO_DRIVE_RESULT_OFS, d); check(d, exp_drive(8'hff, fl, fs, df, ce));
    $display("test_audio done");
  endtask
  initial begin
    repeat (8) @(posedge CLK);
    #2 RST = 1'b0;
    test_reset();
    test_regs();
    reg_wr(ACTUATOR_RATED_LEVEL_OFS, 8'h40); reg_wr(OVERDRIVE_LIMIT_OFS, 8'h80);
    test_ref(1'b1, 8'ha0, 8'h40, 8'h80);
    test_ref(1'b0, 8'h30, 8'h80, 8'h30);
    test_ref(1'b0, 8'h80, 8'h80, 8'h80);
    reg_wr(ACTUATOR_RATED_LEVEL_OFS, 8'h55);
    test_ref(1'b0, 8'h30, 8'h80, 8'h30);
    test_ref(1'b1, 8'h90, 8'h55, 8'h80);
    $display("test_ref done");
    test_audio(8'h20, 8'ha0, 8'h10, 8'hc0);
    test_audio(8'h20, 8'h80, 8'h30, 8'h50);
    test_refuse();
    test_audio(8'h80, 8'h40, 8'h30, 8'h20);
    give_verdict();
  end
endmodule
